/* File: rtl/fadc_top.sv */
// flash converter conversion timing: phase sequencing, comparator latch, decode,
// output register with gated buffers, result fifo and wishbone register slave
// assumes pin inputs are asynchronous to clk_i and the pad ring resolves the enables
//
// Chosen here: the register offsets and the Wishbone register port.

// ------------------------------------------------------------
// result fifo
// ------------------------------------------------------------
module fadc_fifo #(
   parameter int unsigned WIDTH = 7,
   parameter int unsigned DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH+1)-1:0] level_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned LW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [LW-1:0] cnt_q;
   logic push;
   logic pop;

   // handshake terms
   // full and empty come from one count, so level, ready and valid always agree
   assign in_ready_o = (cnt_q != LW'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_q[rd_q];
   assign level_o = cnt_q;

   // storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
         end
         if (push & ~pop) begin
            cnt_q <= LW'(cnt_q + 1'b1);
         end else if (pop & ~push) begin
            cnt_q <= LW'(cnt_q - 1'b1);
         end
      end
   end
endmodule // fadc_fifo

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module fadc_top
   import fadc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // converter pins
   input wire logic conv_clk_i,
   input wire logic phase_sel_i,
   input wire logic data_out_enable_n_i,
   input wire logic all_out_enable_i,
   input wire logic [FADC_NCOMP-1:0] comp_i,
   output logic [FADC_DBITS-1:0] result_bits_o,
   output logic result_bits_oe_o,
   output logic overrange_flag_o,
   output logic overrange_flag_oe_o
);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   // comparators read low when the input is above their tap
   function automatic logic [6:0] fadc_decode(input logic [FADC_NCOMP-1:0] th);
      logic [6:0] cnt;
      cnt = 7'h00;
      for (int i = 0; i < FADC_NCOMP - 1; i++) begin
         cnt = 7'(cnt + {6'h00, ~th[i]});
      end
      if (~th[FADC_NCOMP-1]) begin
         fadc_decode = 7'h7f; // over range: flag plus all ones
      end else begin
         fadc_decode = {1'b0, cnt[5:0]};
      end
   endfunction

   function automatic logic fadc_hit(input logic [3:0] adr, input logic [3:0] off);
      fadc_hit = (adr[3:2] == off[3:2]);
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int unsigned NPIN = 4;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1_q;
   logic [NPIN-1:0] pin_s2_q;
   logic [NPIN-1:0] pin_s3_q;
   logic [NPIN-1:0] pin_f_q;
   logic [FADC_NCOMP-1:0] cmp_s1_q;
   logic [FADC_NCOMP-1:0] cmp_s2_q;
   logic [FADC_NCOMP-1:0] cmp_s3_q;
   logic [FADC_NCOMP-1:0] cmp_f_q;

   assign pin_raw = {all_out_enable_i, data_out_enable_n_i, phase_sel_i, conv_clk_i};

   // three stages; a change counts once stages two and three agree
   // the agree filter costs one cycle but keeps a single metastable settle
   // from being seen as two edges by the phase logic
   // a pin level held for fewer than about two clocks may be lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         pin_f_q <= '0;
         cmp_s1_q <= '1;
         cmp_s2_q <= '1;
         cmp_s3_q <= '1;
         cmp_f_q <= '1;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         cmp_s1_q <= comp_i;
         cmp_s2_q <= cmp_s1_q;
         cmp_s3_q <= cmp_s2_q;
         for (int i = 0; i < NPIN; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_f_q[i] <= pin_s3_q[i];
            end
         end
         for (int i = 0; i < FADC_NCOMP; i++) begin
            if (cmp_s2_q[i] == cmp_s3_q[i]) begin
               cmp_f_q[i] <= cmp_s3_q[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // phase generation
   // ------------------------------------------------------------
   logic clk_f;
   logic phase_f;
   logic ce_n_f;
   logic ce_f;
   logic balance;
   logic balance_q;
   logic start_balance;
   logic start_acquire;

   assign clk_f = pin_f_q[0];
   assign phase_f = pin_f_q[1];
   assign ce_n_f = pin_f_q[2];
   assign ce_f = pin_f_q[3];
   // select complements the clock before the phases are formed
   // both pins are filtered alike, so moving select and clock in the same
   // cycle leaves the phase alone; moving them a cycle apart can make a
   // one-cycle phase pulse that starts a real conversion
   assign balance = clk_f ^ phase_f; // [RULE_03] [RULE_02] [RULE_01]
   assign start_balance = balance & ~balance_q; // end of acquire
   assign start_acquire = ~balance & balance_q; // end of balance

   // phase history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         balance_q <= 1'b0;
      end else begin
         balance_q <= balance;
      end
   end

   // ------------------------------------------------------------
   // comparator latch and output register
   // ------------------------------------------------------------
   logic [FADC_NCOMP-1:0] latch_q;
   logic [6:0] decoded;
   logic [6:0] code_q;

   // latch tracks comparators during acquire, freezes at its end
   // the acquire edge cycle itself is skipped so the frozen word, not a
   // fresh comparator sample, reaches the output register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_q <= '1;
      end else if (~balance & ~start_acquire) begin
         latch_q <= cmp_f_q; // [RULE_09]
      end else if (start_balance) begin
         latch_q <= cmp_f_q; // [RULE_04] [RULE_10] [RULE_12] [RULE_14]
      end
   end

   // decode runs combinationally through the balance phase
   // low comparators are counted, not searched, so a stray bubble in the
   // thermometer shifts the result by one step instead of by a bit weight
   assign decoded = fadc_decode(latch_q); // [RULE_17] [RULE_10]

   // code registers at the start of the following acquire
   // with capen_q set and room left, the fifo takes the same decoded word in the same cycle, so the queued
   // history and the output register never disagree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_q <= FADC_RST_CODE;
      end else if (start_acquire) begin
         code_q <= decoded; // [RULE_05] [RULE_11] [RULE_12] [RULE_14] [RULE_15]
      end
   end

   // pin copies of the stored word and buffer enables
   // one more flop keeps every pin-facing output straight from a register;
   // the stored word therefore reaches the pins one cycle after code_q
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_bits_o <= '0;
         overrange_flag_o <= 1'b0;
         result_bits_oe_o <= 1'b0;
         overrange_flag_oe_o <= 1'b0;
      end else begin
         result_bits_o <= code_q[FADC_DBITS-1:0]; // [RULE_06]
         overrange_flag_o <= code_q[FADC_DBITS];
         result_bits_oe_o <= ce_f & ~ce_n_f; // [RULE_07] [RULE_08]
         overrange_flag_oe_o <= ce_f; // [RULE_08]
      end
   end

   // ------------------------------------------------------------
   // standby watch for pulse operation
   // ------------------------------------------------------------
   localparam int unsigned SBW = $clog2(FADC_STANDBY_CYC + 1);
   logic [SBW-1:0] idle_q;
   logic stale_q;

   // flags a sample held longer than the droop limit
   // counting stops at the limit, so the flag stays up until a new capture
   // instead of wrapping round and clearing itself
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_q <= '0;
         stale_q <= 1'b0;
      end else if (start_balance) begin
         idle_q <= '0;
         stale_q <= 1'b0;
      end else if (idle_q != SBW'(FADC_STANDBY_CYC)) begin
         idle_q <= SBW'(idle_q + 1'b1);
      end else begin
         stale_q <= 1'b1; // [RULE_13]
      end
   end

   // ------------------------------------------------------------
   // result fifo
   // ------------------------------------------------------------
   logic capen_q;
   logic overrun_q;
   logic push_valid;
   logic push_ready;
   logic pop_valid;
   logic pop_ready;
   logic [6:0] pop_data;
   logic [2:0] level;

   assign push_valid = start_acquire & capen_q;

   fadc_fifo #(
      .WIDTH(FADC_CBITS),
      .DEPTH(FADC_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_data_i(decoded),
      .out_valid_o(pop_valid),
      .out_ready_i(pop_ready),
      .out_data_o(pop_data),
      .level_o(level)
   );

   // ------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------
   logic req;
   logic wr_ctrl;
   logic rd_data;
   logic clr_ovr;

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & fadc_hit(wb_adr_i, FADC_OFF_CTRL);
   assign rd_data = req & ~wb_we_i & fadc_hit(wb_adr_i, FADC_OFF_DATA);
   assign pop_ready = rd_data;
   assign clr_ovr = wr_ctrl & wb_dat_i[FADC_CTRL_CLROVR];

   // control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capen_q <= FADC_RST_CAPEN;
      end else if (wr_ctrl) begin
         capen_q <= wb_dat_i[FADC_CTRL_CAPEN];
      end
   end

   // overrun sticky flag, a new loss beats the clear
   // a full fifo drops the newest word; the oldest words stay readable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overrun_q <= 1'b0;
      end else if (push_valid & ~push_ready) begin
         overrun_q <= 1'b1;
      end else if (clr_ovr) begin
         overrun_q <= 1'b0;
      end
   end

   // single wait state answer with registered read data
   // no request is taken while ack stands, so a master that holds stb through
   // the ack cycle cannot pop the fifo twice
   // a data read pops in the cycle it is taken; an empty read pops nothing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= '0;
         if (req & ~wb_we_i) begin
            if (fadc_hit(wb_adr_i, FADC_OFF_CTRL)) begin
               wb_dat_o[FADC_CTRL_CAPEN] <= capen_q;
            end else if (fadc_hit(wb_adr_i, FADC_OFF_STATUS)) begin
               wb_dat_o[FADC_ST_LEVEL+2:FADC_ST_LEVEL] <= level;
               wb_dat_o[FADC_ST_EMPTY] <= ~pop_valid;
               wb_dat_o[FADC_ST_FULL] <= ~push_ready;
               wb_dat_o[FADC_ST_OVERRUN] <= overrun_q;
               wb_dat_o[FADC_ST_BALANCE] <= balance_q;
               wb_dat_o[FADC_ST_STALE] <= stale_q;
               wb_dat_o[FADC_ST_DATA_OE] <= result_bits_oe_o;
               wb_dat_o[FADC_ST_OF_OE] <= overrange_flag_oe_o;
            end else if (fadc_hit(wb_adr_i, FADC_OFF_DATA)) begin
               wb_dat_o[FADC_CBITS-1:0] <= pop_valid ? pop_data : 7'h00;
               wb_dat_o[FADC_DATA_VALID] <= pop_valid;
            end else begin
               wb_dat_o[FADC_CBITS-1:0] <= code_q;
            end
         end
      end
   end
endmodule // fadc_top

/* File: pkg/fadc_pkg.sv */
// constants, register map and field layout of the flash converter timing block
// assumes a single 100 MHz system clock and a classic wishbone master
//
// Contract
// [RULE_01] one conversion per cycle of the single clock, high and low halves are phases
// [RULE_02] polarity select low: balance while clock high, acquire while clock low
// [RULE_03] polarity select inverts the clock before phase generation
// [RULE_04] acquire end freezes all 64 comparator states in a latch stage
// [RULE_05] latched states decode to 7 bits, registered at next acquire start
// [RULE_06] seven stored bits, six data plus overflow, each behind gated buffer
// [RULE_07] active-low enable high floats six data outputs only
// [RULE_08] active-high enable low floats data and overflow outputs
// [RULE_09] select high: rising clock starts acquire, latches follow comparators
// [RULE_10] falling clock captures 64 comparators, starts balance, code decodes
// [RULE_11] next rising clock registers code onto outputs, new acquire starts
// [RULE_12] pulse mode one: single balance pulse, capture leading, register trailing
// [RULE_13] host restarts pulse mode one within the standby limit for droop
// [RULE_14] pulse mode two: two acquire pulses, capture trailing, register leading
// [RULE_15] pulse mode three: two balance pulses, data valid two cycles later
// [RULE_16] host clock drive: balance not too short, active drive, symmetric
// [RULE_17] data is unsigned count 0..63, over-range gives overflow with ones
// [RULE_18] host samples output after delay and only while both enables select
package fadc_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int unsigned FADC_NCOMP = 64;
   localparam int unsigned FADC_DBITS = 6;
   localparam int unsigned FADC_CBITS = 7;
   localparam int unsigned FADC_FIFO_DEPTH = 4;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] FADC_OFF_CTRL = 4'h0;
   localparam logic [3:0] FADC_OFF_STATUS = 4'h4;
   localparam logic [3:0] FADC_OFF_DATA = 4'h8;
   localparam logic [3:0] FADC_OFF_LAST = 4'hc;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned FADC_CTRL_CAPEN = 0;
   localparam int unsigned FADC_CTRL_CLROVR = 1;
   localparam int unsigned FADC_ST_LEVEL = 0;
   localparam int unsigned FADC_ST_EMPTY = 3;
   localparam int unsigned FADC_ST_FULL = 4;
   localparam int unsigned FADC_ST_OVERRUN = 5;
   localparam int unsigned FADC_ST_BALANCE = 6;
   localparam int unsigned FADC_ST_STALE = 7;
   localparam int unsigned FADC_ST_DATA_OE = 8;
   localparam int unsigned FADC_ST_OF_OE = 9;
   localparam int unsigned FADC_DATA_VALID = 8;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic FADC_RST_CAPEN = 1'b0;
   localparam logic [6:0] FADC_RST_CODE = 7'h00;

   // ------------------------------------------------------------
   // timing: longest standby before the held charge droops
   // ------------------------------------------------------------
   localparam int unsigned FADC_CLK_MHZ = 100;
   localparam int unsigned FADC_STANDBY_US = 5;
   localparam int unsigned FADC_STANDBY_CYC = FADC_STANDBY_US * FADC_CLK_MHZ;

endpackage : fadc_pkg

/* File: testbench/fadc_top_monitor.sv */
// checker for the flash converter timing block
// sees only the top ports; bound to every fadc_top below
module fadc_monitor
   import fadc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic conv_clk_i,
   input wire logic phase_sel_i,
   input wire logic data_out_enable_n_i,
   input wire logic all_out_enable_i,
   input wire logic [FADC_DBITS-1:0] result_bits_o,
   input wire logic result_bits_oe_o,
   input wire logic overrange_flag_o,
   input wire logic overrange_flag_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic bal_q;
   logic [7:0] since_q;

   // cycles since the balance level at the pins last moved
   always_ff @(posedge clk_i) begin
      bal_q <= conv_clk_i ^ phase_sel_i;
      if (rst_i || bal_q != (conv_clk_i ^ phase_sel_i)) since_q <= 8'h00;
      else if (since_q != 8'hff) since_q <= since_q + 8'h01;
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_data_oe_off: assert property (data_out_enable_n_i [*8] |-> !result_bits_oe_o)
      else $error("data drivers on while low enable is high");
   a_flag_oe_kept: assert property (all_out_enable_i [*8] |-> overrange_flag_oe_o)
      else $error("overflow driver off while high enable set");
   a_all_oe_off: assert property (!all_out_enable_i [*8] |-> !result_bits_oe_o && !overrange_flag_oe_o)
      else $error("drivers on while high enable is low");
   a_both_oe_on: assert property ((all_out_enable_i && !data_out_enable_n_i) [*8] |-> result_bits_oe_o)
      else $error("data drivers off while both enables select");
   a_over_ones: assert property (overrange_flag_o |-> result_bits_o == 6'h3f)
      else $error("overflow without all data ones");
   a_result_timed: assert property ($changed({overrange_flag_o, result_bits_o}) |-> since_q <= 8'd8)
      else $error("result moved without a phase edge");

   c_overflow: cover property (overrange_flag_o && overrange_flag_oe_o);
   c_result_moves: cover property ($changed(result_bits_o));
   c_valid_pop: cover property (wb_ack_o && wb_dat_o[8]);
endmodule // fadc_monitor

bind fadc_top fadc_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
   .conv_clk_i, .phase_sel_i, .data_out_enable_n_i, .all_out_enable_i, .result_bits_o,
   .result_bits_oe_o, .overrange_flag_o, .overrange_flag_oe_o);

/* File: testbench/fadc_host.sv */
// host capture logic: drives the converter clock and captures the output word
// assumes the bench drives the enables and calls level() for clock phases
module fadc_host
   import fadc_pkg::*;
(
   input wire logic clk_i,
   output logic conv_clk_o,
   input wire logic [FADC_DBITS-1:0] result_bits_i,
   input wire logic result_bits_oe_i,
   input wire logic overrange_flag_i,
   input wire logic overrange_flag_oe_i,
   output logic [FADC_CBITS-1:0] word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [FADC_CBITS-1:0] pins;

   initial conv_clk_o = 1'b0;
   // pins float where the device releases them
   assign pins = {overrange_flag_oe_i ? overrange_flag_i : 1'bz, result_bits_oe_i ? result_bits_i : 6'bz};

   // take the word only while both enables select the outputs
   always_ff @(posedge clk_i) begin
      if (result_bits_oe_i && overrange_flag_oe_i) word_o <= pins;
   end

   // clock actively driven, each level held several cycles
   task automatic level(input logic lvl, input int n);
      @(posedge clk_i);
      conv_clk_o <= lvl;
      repeat (n - 1) @(posedge clk_i);
   endtask
endmodule // fadc_host

/* File: testbench/testbench.sv */
// self-checking bench for the flash converter timing block
// assumes fadc_pkg, fadc_top and the host model are compiled first
module testbench
   import fadc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, conv_clk_i, phase_sel_i;
   logic data_out_enable_n_i, all_out_enable_i, result_bits_oe_o, overrange_flag_o, overrange_flag_oe_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, r;
   logic [63:0] comp_i;
   logic [5:0] result_bits_o;
   logic [6:0] word;
   int fail_count, checked, cycles;

   fadc_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .conv_clk_i, .phase_sel_i, .data_out_enable_n_i, .all_out_enable_i,
      .comp_i, .result_bits_o, .result_bits_oe_o, .overrange_flag_o, .overrange_flag_oe_o);
   fadc_host host (.clk_i, .conv_clk_o(conv_clk_i), .result_bits_i(result_bits_o),
      .result_bits_oe_i(result_bits_oe_o), .overrange_flag_i(overrange_flag_o),
      .overrange_flag_oe_i(overrange_flag_oe_o), .word_o(word));

   always #5 clk_i = ~clk_i;

   // cut a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [63:0] therm(input int n);
      return n > 63 ? 64'h0 : ~((64'h1 << n) - 64'h1);
   endfunction

   function automatic logic [31:0] code(input int n);
      return n > 63 ? 32'h7f : 32'(n);
   endfunction

   // one classic bus cycle, held until ack is seen
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
      r = wb_dat_o;
      if (n >= 50) check(32'h0, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic t_reset;
      check({result_bits_oe_o, overrange_flag_oe_o, overrange_flag_o, result_bits_o}, 32'h0);
      wb(1'b0, FADC_OFF_CTRL, 32'h0);
      check(r, 32'h0);
      wb(1'b0, FADC_OFF_STATUS, 32'h0);
      check(r & 32'h1f, 32'h08);
      $display("reset test done");
   endtask

   task automatic t_codes;
      int tbl[6] = '{0, 1, 31, 32, 63, 64};
      foreach (tbl[i]) begin
         comp_i <= therm(tbl[i]);
         host.level(1'b0, 8);
         host.level(1'b1, 8);
         comp_i <= therm(63 - tbl[i] % 64);
         host.level(1'b1, 4);
         host.level(1'b0, 10);
         check({overrange_flag_o, result_bits_o}, code(tbl[i]));
         check(word, code(tbl[i]));
         wb(1'b0, FADC_OFF_LAST, 32'h0);
         check(r & 32'h7f, code(tbl[i]));
      end
      $display("code test done");
   endtask

   task automatic t_enable;
      logic [3:0] tbl[4] = '{4'b0111, 4'b1101, 4'b1000, 4'b0000};
      foreach (tbl[i]) begin
         @(posedge clk_i);
         data_out_enable_n_i <= tbl[i][3];
         all_out_enable_i <= tbl[i][2];
         repeat (10) @(posedge clk_i);
         check({result_bits_oe_o, overrange_flag_oe_o}, 32'(tbl[i][1:0]));
      end
      data_out_enable_n_i <= 1'b0;
      all_out_enable_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      $display("enable test done");
   endtask

   task automatic t_pulse;
      host.level(1'b1, 10);
      phase_sel_i <= 1'b1; // same clock level now reads as acquire
      comp_i <= therm(5);
      host.level(1'b1, 10);
      host.level(1'b0, 10);
      host.level(1'b1, 10);
      check({overrange_flag_o, result_bits_o}, code(5));
      repeat (FADC_STANDBY_CYC) @(posedge clk_i);
      wb(1'b0, FADC_OFF_STATUS, 32'h0);
      check(32'(r[FADC_ST_STALE]), 32'h1);
      phase_sel_i <= 1'b0;
      comp_i <= therm(40);
      host.level(1'b1, 10);
      host.level(1'b0, 10);
      host.level(1'b1, 4);
      comp_i <= therm(2);
      host.level(1'b1, 6);
      host.level(1'b0, 10);
      check({overrange_flag_o, result_bits_o}, code(40));
      host.level(1'b1, 10);
      comp_i <= therm(17);
      host.level(1'b0, 10);
      host.level(1'b1, 10);
      host.level(1'b0, 10);
      check({overrange_flag_o, result_bits_o}, code(17));
      $display("pulse test done");
   endtask

   task automatic t_fifo;
      wb(1'b1, FADC_OFF_CTRL, 32'h1);
      for (int i = 0; i < 5; i++) begin
         comp_i <= therm(10 + i);
         host.level(1'b0, 8);
         host.level(1'b1, 8);
      end
      host.level(1'b0, 10);
      wb(1'b1, FADC_OFF_STATUS, 32'h0);
      wb(1'b0, FADC_OFF_STATUS, 32'h0);
      check(r & 32'h3ff, 32'h334);
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, FADC_OFF_DATA, 32'h0);
         check(r, i < 4 ? 32'h100 | code(10 + i) : 32'h0);
      end
      wb(1'b1, FADC_OFF_CTRL, 32'h2);
      wb(1'b0, FADC_OFF_STATUS, 32'h0);
      check(r & 32'h3f, 32'h08);
      wb(1'b0, FADC_OFF_CTRL, 32'h0);
      check(r, 32'h0);
      $display("fifo test done");
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, phase_sel_i, data_out_enable_n_i} = 5'h0;
      all_out_enable_i = 1'b1;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      comp_i = 64'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      t_reset();
      repeat (8) @(posedge clk_i);
      t_codes();
      t_enable();
      t_pulse();
      t_fifo();
      wrap_up();
   end
endmodule // testbench
